// ==== design/ebw_ctrl.sv ====
/*
 * External bus window controller: address decode, window lookup, bus cycle sequencer.
 * Assumes requests come from a core side that holds them until reqReady, and that
 * the two-way data port is resolved outside from dOut and dOe.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ebw_consts.svh"

module ebw_ctrl (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Configuration.
    input wire logic singleChip,
    input wire logic [2:0] segLines,
    input wire ebw_pkg::ebw_range_s [4:1] winRange,
    input wire ebw_pkg::ebw_fcfg_s [4:0] funcCfg,
    input wire ebw_pkg::ebw_tcfg_s [4:0] timeCfg,
    // Core request and answer.
    input wire logic reqValid,
    input wire ebw_pkg::ebw_req_s req,
    output logic reqReady,
    output ebw_pkg::ebw_rsp_s rsp,
    output logic ioAccess,
    // External bus pins.
    output logic refClockOut,
    output logic [3:0] csN,
    output logic rdN,
    output logic wrN,
    output logic ale,
    output logic [15:0] addressOutPort,
    output logic [7:0] segPort,
    output logic [15:0] sharedDataPortOut,
    output logic [1:0] sharedDataPortOe,
    input wire logic [15:0] sharedDataPortIn,
    // Internal peripheral bus.
    output logic periphSel,
    output logic [23:0] periphAddr,
    output logic periphWrite,
    output logic [15:0] periphWdata,
    input wire logic [15:0] periphRdata
);
    import ebw_pkg::*;

    // ------------------------------------------------------------
    // State and decode.
    // ------------------------------------------------------------
    ebw_st_s s;
    ebw_st_s n;
    ebw_kind_e reqKind;
    logic [2:0] hit;
    logic [3:0] winHit;
    logic tick;

    // Past ST_IDLE, the sequencer moves only on edges where the reference clock rises.
    assign tick = ~s.refClk;

    always_comb begin
        reqKind = K_LOCAL;
        if (req.addr <= `EBW_EXT0_HI) begin
            reqKind = K_EXT;
        end else if (req.addr <= `EBW_INT_HI) begin
            reqKind = K_LOCAL;
        end else if (req.addr <= `EBW_EXT1_HI) begin
            reqKind = K_EXT;
        end else if (req.addr <= `EBW_PERI_HI) begin
            reqKind = K_PERIPH;
        end else if (req.addr <= `EBW_IO_HI) begin
            reqKind = K_IO;
        end else if (req.addr <= `EBW_EXT2_HI) begin
            reqKind = K_EXT;
        end else if (req.addr >= `EBW_TRAP_LO && !req.write) begin
            reqKind = K_TRAP;
        end
        if (singleChip && (reqKind == K_EXT || reqKind == K_IO)) begin
            reqKind = K_NONE;
        end
    end

    // Window match on 4-Kbyte granules; size gives the count of ignored low bits.
    always_comb begin
        for (int w = 1; w <= 4; w++) begin
            winHit[w-1] = (((req.addr[23:12] ^ winRange[w].base) >> winRange[w].size)
                          == 12'h000);
        end
        hit = 3'h0;
        for (int w = 1; w <= 4; w++) begin
            if (winHit[w-1]) begin
                hit = w[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Bus phase helpers.
    // ------------------------------------------------------------
    function automatic ebw_bus_s addrPhase(input ebw_st_s x, input logic [2:0] lines);
        ebw_bus_s b;
        logic [7:0] mask;
        b = x.bus;
        mask = 8'h00;
        for (int i = 0; i < `EBW_SEG_W; i++) begin
            mask[i] = (i < int'(lines));
        end
        if (x.kind != K_PERIPH) begin
            b.ale = 1'b1;
            b.segPort = x.req.addr[23:16] & mask;
            b.csN = `EBW_CS_IDLE;
            if (x.csEn && x.region != `EBW_WIN_CNT) begin
                b.csN[x.region[1:0]] = 1'b0;
            end
            if (x.mode == MD_MUX16 || x.mode == MD_MUX8) begin
                b.dOut = x.req.addr[15:0];
                b.dOe = 2'h3;
                b.addrPort = 16'h0000;
            end else begin
                b.addrPort = x.req.addr[15:0];
                b.dOe = 2'h0;
            end
        end
        return b;
    endfunction

    function automatic ebw_bus_s dataPhase(input ebw_st_s x);
        ebw_bus_s b;
        logic narrow;
        b = x.bus;
        narrow = (x.mode == MD_MUX8 || x.mode == MD_DEMUX8);
        b.ale = 1'b0;
        b.dOe = 2'h0;
        if (x.kind != K_PERIPH) begin
            b.rdN = x.req.write;
            b.wrN = ~x.req.write;
            if (x.req.write) begin
                if (narrow) begin
                    b.dOut = {8'h00, x.beat ? x.req.wdata[15:8] : x.req.wdata[7:0]};
                    b.dOe = 2'h1;
                end else if (x.req.byteAcc) begin
                    b.dOut = {x.req.wdata[7:0], x.req.wdata[7:0]};
                    b.dOe = x.req.addr[0] ? 2'h2 : 2'h1;
                end else begin
                    b.dOut = x.req.wdata;
                    b.dOe = 2'h3;
                end
            end
        end
        return b;
    endfunction

    // ------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] din;
        logic narrow;
        din = (s.kind == K_PERIPH) ? periphRdata : sharedDataPortIn;
        narrow = (s.mode == MD_MUX8 || s.mode == MD_DEMUX8);
        n = s;
        n.refClk = ~s.refClk;
        n.rsp.valid = 1'b0;
        case (s.st)
            ST_IDLE: begin
                if (reqValid) begin
                    n.req = req;
                    n.kind = reqKind;
                    n.region = hit;
                    n.mode = funcCfg[hit].mode;
                    n.csEn = funcCfg[hit].csEn;
                    n.waits = timeCfg[hit].waitStates;
                    n.beat = 1'b0;
                    n.rsp.rdata = 16'h0000;
                    if (reqKind == K_EXT || reqKind == K_IO || reqKind == K_PERIPH) begin
                        n.st = ST_START;
                        n.ready = 1'b0;
                        n.ioAcc = (reqKind == K_IO);
                        if (reqKind == K_PERIPH) begin
                            n.mode = MD_DEMUX16;
                        end
                    end else begin
                        n.rsp.valid = 1'b1;
                        n.rsp.kind = reqKind;
                        if (reqKind == K_TRAP) begin
                            n.rsp.rdata = `EBW_TRAP_CODE;
                        end
                    end
                end
            end
            ST_START: begin
                if (tick) begin
                    n.bus = addrPhase(s, segLines);
                    n.periphSel = (s.kind == K_PERIPH);
                    n.st = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (tick) begin
                    n.bus = dataPhase(s);
                    n.waitCnt = s.waits;
                    n.st = ST_DATA;
                end
            end
            ST_DATA: begin
                if (tick) begin
                    if (s.waitCnt != 4'h0) begin
                        n.waitCnt = s.waitCnt - 4'h1;
                    end else begin
                        n.bus.rdN = 1'b1;
                        n.bus.wrN = 1'b1;
                        n.bus.dOe = 2'h0;
                        if (narrow) begin
                            if (s.beat) begin
                                n.rsp.rdata[15:8] = din[7:0];
                            end else begin
                                n.rsp.rdata[7:0] = din[7:0];
                            end
                        end else if (s.req.byteAcc) begin
                            n.rsp.rdata = {8'h00, s.req.addr[0] ? din[15:8] : din[7:0]};
                        end else begin
                            n.rsp.rdata = din;
                        end
                        if (narrow && !s.req.byteAcc && !s.beat) begin
                            // Word on an 8-bit bus: second beat at the odd byte.
                            n.beat = 1'b1;
                            n.req.addr[0] = 1'b1;
                            n.bus = addrPhase(n, segLines);
                            n.st = ST_ADDR;
                        end else begin
                            n.bus.csN = `EBW_CS_IDLE;
                            n.bus.ale = 1'b0;
                            n.periphSel = 1'b0;
                            n.ioAcc = 1'b0;
                            n.rsp.valid = 1'b1;
                            n.rsp.kind = s.kind;
                            n.ready = 1'b1;
                            n.st = ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
                n.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.ready <= 1'b1;
            s.bus.csN <= `EBW_CS_IDLE;
            s.bus.rdN <= 1'b1;
            s.bus.wrN <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    assign reqReady = s.ready;
    assign rsp = s.rsp;
    assign ioAccess = s.ioAcc;
    assign refClockOut = s.refClk;
    assign csN = s.bus.csN;
    assign rdN = s.bus.rdN;
    assign wrN = s.bus.wrN;
    assign ale = s.bus.ale;
    assign addressOutPort = s.bus.addrPort;
    assign segPort = s.bus.segPort;
    assign sharedDataPortOut = s.bus.dOut;
    assign sharedDataPortOe = s.bus.dOe;
    assign periphSel = s.periphSel;
    assign periphAddr = s.req.addr;
    assign periphWrite = s.req.write;
    assign periphWdata = s.req.wdata;

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_addrPhase;
        s.st == ST_ADDR && s.kind != K_PERIPH;
    endsequence
    sequence s_dataPhase;
        s.st == ST_DATA [*2];
    endsequence

    property p_single;
        singleChip && reqValid && reqReady && reqKind == K_NONE
            |=> rsp.valid && csN == `EBW_CS_IDLE;
    endproperty
    a_single: assert property (p_single) else $error("single chip access reached bus");

    property p_csHold;
        s_addrPhase ##1 s_dataPhase |-> csN == $past(csN, 2);
    endproperty
    a_csHold: assert property (p_csHold) else $error("chip select moved in cycle");

    property p_refEdge;
        $changed(ale) |-> refClockOut;
    endproperty
    a_refEdge: assert property (p_refEdge) else $error("bus change off rising edge");

    property p_win4;
        s.region == `EBW_WIN_CNT |-> csN == `EBW_CS_IDLE;
    endproperty
    a_win4: assert property (p_win4) else $error("window 4 drove a chip select");

    property p_local;
        reqValid && reqReady && req.addr > `EBW_EXT0_HI && req.addr <= `EBW_INT_HI
            |=> rsp.valid && rsp.kind == K_LOCAL && s.st == ST_IDLE;
    endproperty
    a_local: assert property (p_local) else $error("internal area left the chip");

    property p_trap;
        reqValid && reqReady && !req.write && req.addr >= `EBW_TRAP_LO
            |=> rsp.valid && rsp.rdata == `EBW_TRAP_CODE;
    endproperty
    a_trap: assert property (p_trap) else $error("no trap code returned");

    property p_mux;
        ale && (s.mode == MD_MUX16 || s.mode == MD_MUX8)
            |-> sharedDataPortOe == 2'h3 && sharedDataPortOut == s.req.addr[15:0];
    endproperty
    a_mux: assert property (p_mux) else $error("mux address missing");

    property p_demux;
        s.st == ST_DATA && s.kind != K_PERIPH && (s.mode == MD_DEMUX16 || s.mode == MD_DEMUX8)
            |-> addressOutPort == s.req.addr[15:0];
    endproperty
    a_demux: assert property (p_demux) else $error("demux address dropped");

    property p_ext;
        reqValid && reqReady && !singleChip && req.addr <= `EBW_EXT0_HI
            |=> s.st == ST_START ##[1:2] ale;
    endproperty
    a_ext: assert property (p_ext) else $error("external access not started");
endmodule
`default_nettype wire

// ==== design/ebw_consts.svh ====
/*
 * Address map bounds, reset values and the trap code of the external bus window controller.
 * Assumes it is included by its bare name from the design file and the bench.
 */
`ifndef EBW_CONSTS_SVH
`define EBW_CONSTS_SVH

`define EBW_EXT0_HI 24'h007FFF
`define EBW_INT_HI 24'h00FFFF
`define EBW_EXT1_HI 24'h1FFFFF
`define EBW_PERI_HI 24'h2007FF
`define EBW_IO_HI 24'h3FFFFF
`define EBW_EXT2_HI 24'hBEFFFF
`define EBW_TRAP_LO 24'hFFF000
`define EBW_TRAP_CODE 16'h0FFF
`define EBW_WIN_CNT 3'h4
`define EBW_CS_IDLE 4'hF
`define EBW_SEG_W 8

`endif

// ==== design/ebw_pkg.sv ====
/*
 * Types of the external bus window controller.
 * Assumes ebw_consts.svh is on the include path.
 */
package ebw_pkg;
    typedef enum logic [1:0] {
        MD_DEMUX16 = 2'h0,
        MD_MUX16 = 2'h1,
        MD_MUX8 = 2'h2,
        MD_DEMUX8 = 2'h3
    } ebw_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_START = 2'h1,
        ST_ADDR = 2'h3,
        ST_DATA = 2'h2
    } ebw_state_e;

    typedef enum logic [2:0] {
        K_LOCAL = 3'h0,
        K_EXT = 3'h1,
        K_IO = 3'h2,
        K_PERIPH = 3'h3,
        K_TRAP = 3'h4,
        K_NONE = 3'h5
    } ebw_kind_e;

    typedef struct packed {
        logic [23:0] addr;
        logic write;
        logic byteAcc;
        logic [15:0] wdata;
    } ebw_req_s;

    typedef struct packed {
        logic valid;
        ebw_kind_e kind;
        logic [15:0] rdata;
    } ebw_rsp_s;

    typedef struct packed {
        logic [11:0] base;
        logic [3:0] size;
    } ebw_range_s;

    typedef struct packed {
        logic csEn;
        ebw_mode_e mode;
    } ebw_fcfg_s;

    typedef struct packed {
        logic [3:0] waitStates;
    } ebw_tcfg_s;

    typedef struct packed {
        logic [3:0] csN;
        logic rdN;
        logic wrN;
        logic ale;
        logic [15:0] addrPort;
        logic [7:0] segPort;
        logic [15:0] dOut;
        logic [1:0] dOe;
    } ebw_bus_s;

    typedef struct packed {
        ebw_state_e st;
        logic refClk;
        logic ready;
        ebw_req_s req;
        ebw_kind_e kind;
        logic [2:0] region;
        ebw_mode_e mode;
        logic csEn;
        logic [3:0] waits;
        logic [3:0] waitCnt;
        logic beat;
        ebw_bus_s bus;
        logic periphSel;
        logic ioAcc;
        ebw_rsp_s rsp;
    } ebw_st_s;
endpackage

// ==== tb/ebw_mem_model.sv ====
/*
 * Behavioural external memory and internal peripheral for the bus window controller.
 * Assumes registered active-low strobes and a bench that names the bus mode in use.
 */
`timescale 1ns/100ps
`default_nettype none

module ebw_mem_model (
    // Clock and bus mode.
    input wire logic clk,
    input wire ebw_pkg::ebw_mode_e busMode,
    // External bus.
    input wire logic rdN,
    input wire logic wrN,
    input wire logic ale,
    input wire logic [15:0] addressOutPort,
    input wire logic [7:0] segPort,
    input wire logic [15:0] sharedDataPortOut,
    input wire logic [1:0] sharedDataPortOe,
    output logic [15:0] sharedDataPortIn,
    // Internal peripheral bus.
    input wire logic periphSel,
    input wire logic [23:0] periphAddr,
    output logic [15:0] periphRdata
);
    import ebw_pkg::*;
    logic [7:0] mem [logic [23:0]];
    logic [23:0] a;
    logic mux;
    logic narrow;
    assign mux = (busMode == MD_MUX16) || (busMode == MD_MUX8);
    assign narrow = busMode[1];
    function automatic logic [7:0] rd(input logic [23:0] x);
        return mem.exists(x) ? mem[x] : (x[7:0] ^ 8'h5A);
    endfunction
    initial begin
        sharedDataPortIn = 16'h0000;
        periphRdata = 16'h0000;
    end
    // ----------------------------------------
    // Address latch, writes and read drive.
    // ----------------------------------------
    always @(posedge clk) begin
        if (ale === 1'b1) begin
            a = {segPort, mux ? sharedDataPortOut : addressOutPort};
        end
        if (wrN === 1'b0 && narrow && sharedDataPortOe[0]) begin
            mem[a] = sharedDataPortOut[7:0];
        end
        if (wrN === 1'b0 && !narrow && sharedDataPortOe[0]) begin
            mem[{a[23:1], 1'b0}] = sharedDataPortOut[7:0];
        end
        if (wrN === 1'b0 && !narrow && sharedDataPortOe[1]) begin
            mem[{a[23:1], 1'b1}] = sharedDataPortOut[15:8];
        end
    end
    // Released lines show a pattern that changes every cycle.
    always @(negedge clk) begin
        if (rdN === 1'b0 && narrow) begin
            sharedDataPortIn <= {~sharedDataPortIn[15:8], rd(a)};
        end else if (rdN === 1'b0) begin
            sharedDataPortIn <= {rd({a[23:1], 1'b1}), rd({a[23:1], 1'b0})};
        end else begin
            sharedDataPortIn <= ~sharedDataPortIn;
        end
        if (periphSel === 1'b1) begin
            periphRdata <= {periphAddr[7:0] ^ 8'h3C, periphAddr[15:8]};
        end else begin
            periphRdata <= ~periphRdata;
        end
    end
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench of the external bus window controller.
 * Assumes ebw_pkg, ebw_consts.svh and ebw_mem_model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ebw_consts.svh"

module tb_top;
    import ebw_pkg::*;
    typedef struct packed {
        ebw_kind_e kind;
        logic [15:0] rdata;
        logic [15:0] rmask;
        logic [3:0] cs;
        logic [15:0] aleN;
        logic [15:0] strN;
        logic io;
        logic [7:0] seg;
        logic [15:0] a16;
        logic mux;
        logic [15:0] lat;
        logic wr;
        logic [15:0] wd;
    } ebw_note_s;
    logic clk, rst_n, singleChip, reqValid, reqReady, ioAccess, refClockOut;
    logic rdN, wrN, ale, periphSel, periphWrite, io, ps, aleD;
    logic [2:0] segLines;
    ebw_range_s [4:1] winRange;
    ebw_fcfg_s [4:0] funcCfg;
    ebw_tcfg_s [4:0] timeCfg;
    ebw_req_s req;
    ebw_rsp_s rsp;
    ebw_mode_e busMode;
    logic [3:0] csN, seenCs;
    logic [15:0] addressOutPort, sharedDataPortOut, sharedDataPortIn, periphWdata, periphRdata;
    logic [15:0] lat, csCnt, aleC, strC, aOut, dOut;
    logic [7:0] segPort, seg;
    logic [1:0] sharedDataPortOe;
    logic [23:0] periphAddr;
    ebw_note_s notes [$];
    logic [7:0] shadow [logic [23:0]];
    logic [31:0] seed = 32'h0000ECBA;
    int errCount = 0;
    int nTests = 0;
    int cycles = 0;
    logic [23:0] decAddr [14] = '{24'h000000, 24'h007FFE, 24'h008000, 24'h00FFFE, 24'h010000,
        24'h1FFFFE, 24'h200000, 24'h2007FE, 24'h200800, 24'h3FFFFE, 24'h400000, 24'hBEFFFE,
        24'hBF0000, 24'hFFF000};
    logic [23:0] winAddr [6] = '{24'h110000, 24'h480000, 24'h440000, 24'h5C0000, 24'h508000,
        24'h300000};

    ebw_ctrl DUT (.clk(clk), .rst_n(rst_n), .singleChip(singleChip), .segLines(segLines),
        .winRange(winRange), .funcCfg(funcCfg), .timeCfg(timeCfg), .reqValid(reqValid),
        .req(req), .reqReady(reqReady), .rsp(rsp), .ioAccess(ioAccess),
        .refClockOut(refClockOut), .csN(csN), .rdN(rdN), .wrN(wrN), .ale(ale),
        .addressOutPort(addressOutPort), .segPort(segPort),
        .sharedDataPortOut(sharedDataPortOut), .sharedDataPortOe(sharedDataPortOe),
        .sharedDataPortIn(sharedDataPortIn), .periphSel(periphSel), .periphAddr(periphAddr),
        .periphWrite(periphWrite), .periphWdata(periphWdata), .periphRdata(periphRdata));
    ebw_mem_model memModel (.clk(clk), .busMode(busMode), .rdN(rdN), .wrN(wrN), .ale(ale),
        .addressOutPort(addressOutPort), .segPort(segPort),
        .sharedDataPortOut(sharedDataPortOut), .sharedDataPortOe(sharedDataPortOe),
        .sharedDataPortIn(sharedDataPortIn), .periphSel(periphSel), .periphAddr(periphAddr),
        .periphRdata(periphRdata));

    // ----------------------------------------
    // Helpers and expectations.
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] sh(input logic [23:0] k);
        return shadow.exists(k) ? shadow[k] : (k[7:0] ^ 8'h5A);
    endfunction
    function automatic int region(input logic [23:0] x);
        for (int w = 4; w >= 1; w--) begin
            if ((x[23:12] >> winRange[w].size) == (winRange[w].base >> winRange[w].size)) begin
                return w;
            end
        end
        return 0;
    endfunction
    function automatic ebw_kind_e kindOf(input logic [23:0] x, input logic wr);
        if (x <= 24'h007FFF || (x >= 24'h010000 && x <= 24'h1FFFFF)
                || (x >= 24'h400000 && x <= 24'hBEFFFF)) begin
            return singleChip ? K_NONE : K_EXT;
        end
        if (x >= 24'h200800 && x <= 24'h3FFFFF) begin
            return singleChip ? K_NONE : K_IO;
        end
        if (x >= 24'h200000 && x <= 24'h2007FF) begin
            return K_PERIPH;
        end
        return (x >= 24'hFFF000 && !wr) ? K_TRAP : K_LOCAL;
    endfunction
    task automatic cmpRsp(input logic [15:0] got, exp, msk, input string m);
        nTests++;
        if ((got & msk) !== (exp & msk)) begin
            errCount++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic cmpPin(input logic [15:0] got, exp, input string m);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wrapUp();
        if (errCount == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic access(input logic [23:0] x, input logic wr, bt, input logic [15:0] wd);
        ebw_note_s n;
        int r;
        logic bus;
        logic [15:0] ph;
        logic [23:0] k;
        ebw_mode_e m;
        n = '0;
        n.kind = kindOf(x, wr);
        r = region(x);
        m = funcCfg[r].mode;
        bus = (n.kind == K_EXT) || (n.kind == K_IO);
        ph = (bus && !bt && m[1]) ? 16'h2 : 16'h1;
        n.cs = (bus && r < 4 && funcCfg[r].csEn) ? (4'h1 << r) : 4'h0;
        n.wr = wr;
        n.wd = wd;
        n.aleN = bus ? 16'h2 * ph : 16'h0;
        n.strN = bus ? 16'h2 * ph * (16'h1 + timeCfg[r].waitStates) : 16'h0;
        n.io = n.kind == K_IO;
        n.seg = x[23:16] & ((8'h01 << segLines) - 8'h01);
        n.a16 = x[15:0];
        n.mux = (m == MD_MUX16) || (m == MD_MUX8);
        n.lat = (bus || n.kind == K_PERIPH) ? 16'h0 : 16'h1;
        k = {n.seg, x[15:0]};
        if (n.kind == K_TRAP) begin
            n.rdata = `EBW_TRAP_CODE;
            n.rmask = 16'hFFFF;
        end
        if (bus && !wr) begin
            n.rdata = {sh(k | 24'h1), sh(k)};
            n.rmask = bt ? 16'h00FF : 16'hFFFF;
        end
        if (n.kind == K_PERIPH && !wr) begin
            n.rdata = {x[7:0] ^ 8'h3C, x[15:8]};
            n.rmask = 16'hFFFF;
        end
        if (bus && wr) begin
            shadow[k] = wd[7:0];
            if (!bt) begin
                shadow[k | 24'h1] = wd[15:8];
            end
        end
        @(negedge clk);
        reqValid = 1'b1;
        req = '{x, wr, bt, wd};
        busMode = m;
        notes.push_back(n);
        @(posedge clk);
        while (reqReady !== 1'b1) @(posedge clk);
        if (n.lat == 16'h0) begin
            @(negedge clk);
            reqValid = 1'b0;
            @(posedge clk);
            while (reqReady !== 1'b1) @(posedge clk);
        end
    endtask

    // ----------------------------------------
    // Clock, timeout and output watcher.
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            wrapUp();
        end
    end
    always @(posedge clk) begin
        ebw_note_s n;
        lat++;
        if (csN !== 4'hF) begin
            seenCs |= ~csN;
            csCnt++;
        end
        if (ale === 1'b1 && aleD !== 1'b1) cmpPin(16'(refClockOut), 16'h1, "ref edge");
        if (ale === 1'b1 && aleC == 16'h0) begin
            seg = segPort;
            aOut = addressOutPort;
            dOut = sharedDataPortOut;
        end
        aleC += 16'(ale === 1'b1);
        strC += 16'(rdN === 1'b0 || wrN === 1'b0);
        io |= ioAccess === 1'b1;
        ps |= periphSel === 1'b1;
        aleD = ale;
        if (rsp.valid === 1'b1) begin
            n = notes.pop_front();
            cmpRsp(16'(rsp.kind), 16'(n.kind), 16'hFFFF, "kind");
            cmpRsp(rsp.rdata, n.rdata, n.rmask, "read data");
            cmpPin(16'(seenCs), 16'(n.cs), "chip select");
            cmpPin(csCnt, (n.cs != 4'h0) ? aleC + strC : 16'h0, "select span");
            cmpPin(aleC, n.aleN, "address phase");
            cmpPin(strC, n.strN, "data phase");
            cmpPin(16'(io), 16'(n.io), "io flag");
            cmpPin(16'(ps), 16'(n.kind == K_PERIPH), "periph cycle");
            if (n.aleN != 16'h0) begin
                cmpPin(16'(seg), 16'(n.seg), "segment");
                cmpPin(n.mux ? dOut : aOut, n.a16, "address");
            end
            if (n.kind == K_PERIPH) begin
                cmpPin(periphAddr[15:0], n.a16, "periph addr");
                cmpPin(16'(periphWrite), 16'(n.wr), "periph dir");
                cmpPin(periphWdata, n.wd, "periph data");
            end
            if (n.lat != 16'h0) cmpPin(lat, n.lat, "latency");
        end
        if (reqValid === 1'b1 && reqReady === 1'b1) begin
            {lat, csCnt, aleC, strC, seenCs, io, ps} = '0;
        end
    end

    // ----------------------------------------
    // Main sequence.
    // ----------------------------------------
    initial begin
        logic [23:0] a;
        logic [31:0] d;
        rst_n = 1'b0;
        singleChip = 1'b0;
        segLines = 3'h7;
        reqValid = 1'b0;
        req = '0;
        busMode = MD_DEMUX16;
        winRange[1] = {12'h400, 4'h8};
        winRange[2] = {12'h440, 4'h4};
        winRange[3] = {12'h500, 4'h8};
        winRange[4] = {12'h508, 4'h0};
        funcCfg[0] = {1'b1, MD_DEMUX16};
        funcCfg[1] = {1'b1, MD_MUX16};
        funcCfg[2] = {1'b1, MD_MUX8};
        funcCfg[3] = {1'b1, MD_DEMUX8};
        funcCfg[4] = {1'b1, MD_DEMUX16};
        timeCfg = {4'h3, 4'h0, 4'h2, 4'h1, 4'h0};
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        cmpPin(16'(csN), 16'h000F, "idle select");
        foreach (decAddr[i]) access(decAddr[i], 1'b0, 1'b0, 16'h0000);
        access(24'hFFF002, 1'b1, 1'b0, 16'h0000);
        foreach (winAddr[i]) begin
            d = rnd();
            a = winAddr[i] | {12'h000, d[11:1], 1'b0};
            access(a, 1'b1, 1'b0, d[31:16]);
            access(a, 1'b0, 1'b0, 16'h0000);
            access(a | 24'h1, 1'b1, 1'b1, d[23:8]);
            access(a | 24'h1, 1'b0, 1'b1, 16'h0000);
            access(a, 1'b0, 1'b1, 16'h0000);
        end
        access(24'h200402, 1'b1, 1'b0, d[15:0]);
        @(negedge clk);
        segLines = 3'h2;
        funcCfg[3] = {1'b0, MD_DEMUX8};
        access(24'hBE1234, 1'b1, 1'b0, 16'h5AC3);
        access(24'hBE1234, 1'b0, 1'b0, 16'h0000);
        access(24'h5C0010, 1'b0, 1'b0, 16'h0000);
        @(negedge clk);
        singleChip = 1'b1;
        access(24'h480000, 1'b0, 1'b0, 16'h0000);
        access(24'h300000, 1'b1, 1'b0, 16'h1234);
        access(24'h008000, 1'b0, 1'b0, 16'h0000);
        @(negedge clk);
        reqValid = 1'b0;
        repeat (4) @(posedge clk);
        cmpPin(16'(notes.size()), 16'h0000, "pending");
        wrapUp();
    end
endmodule

`default_nettype wire
